// file: rtl/fic_irq_ctrl.sv
// Five source interrupt controller: flags, enables, priority and call
`timescale 1ns/1ps
module fic_irq_ctrl #(
    parameter logic [1:0] EDGE_PIN0 = fic_pkg::EDGE_FALL,
    parameter logic [1:0] EDGE_PIN1 = fic_pkg::EDGE_FALL
) (
    // Clock, reset, enable
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          clkEn,
    // Register port
    input  wire logic [7:0]    regAddr,
    input  wire logic [7:0]    regWrData,
    input  wire logic          regWrEn,
    input  wire logic          regRdEn,
    output logic [7:0]         regRdData,
    // External pins, asynchronous
    input  wire logic          extIrqPinZero,
    input  wire logic          extIrqPinOne,
    // Internal event pulses, same clock
    input  wire logic          timerOvf,
    input  wire logic          timeBaseTick,
    input  wire logic          clockTick,
    // Core sequencer and return stack
    input  wire logic          coreAccept,
    input  wire logic          stackFull,
    input  wire logic          returnFromIrq,
    input  wire logic          returnSub,
    output fic_pkg::fic_call_t irqCall,
    output logic               pushPc,
    output logic               wakeReq
);

    // State
    fic_pkg::fic_src_t flags_r, flags_nxt;
    fic_pkg::fic_src_t enables_r, enables_nxt;
    logic              master_r, master_nxt;
    logic              testBit_r, testBit_nxt;
    logic [7:0]        rdData_r, rdData_nxt;
    fic_pkg::fic_call_t call_r, call_nxt;

    // Combinational helpers
    fic_pkg::fic_src_t events, pending, grant;
    logic [7:0]        grantVec;
    logic              anyPending;
    logic              ackGo;
    logic              wrCtrl0, wrCtrl1;
    logic [1:0]        pinRaw, pinEdge;

    localparam logic [1:0] EDGE_TAB [2] = '{EDGE_PIN0, EDGE_PIN1};

    assign pinRaw = {extIrqPinOne, extIrqPinZero};

    // One synchroniser and edge detector per external pin
    for (genvar p = 0; p < 2; p++) begin : g_pin
        fic_pin_edge #(
            .EDGE_MODE (EDGE_TAB[p])
        ) u_edge (
            .clk_sys   (clk_sys),
            .sys_rst   (sys_rst),
            .clkEn     (clkEn),
            .pinRaw    (pinRaw[p]),
            .edgePulse (pinEdge[p])
        );
    end

    // Source events in flag order
    always_comb begin
        events.ext0 = pinEdge[0];
        events.ext1 = pinEdge[1];
        events.tmr  = timerOvf;
        events.tb   = timeBaseTick;
        events.rtc  = clockTick;
    end

    // Only flags whose own enable is set compete
    assign pending = flags_r & enables_r;

    fic_prio u_prio (
        .req    (pending),
        .grant  (grant),
        .vector (grantVec),
        .any    (anyPending)
    );

    // Acknowledge needs master enable, room on the stack and a boundary
    assign ackGo = clkEn & coreAccept & master_r & anyPending
                 & ~stackFull;

    // Register address decode
    always_comb begin
        wrCtrl0 = 1'b0;
        wrCtrl1 = 1'b0;
        if (regWrEn && regAddr == fic_pkg::ADDR_CTRL0) begin
            wrCtrl0 = 1'b1;
        end else if (regWrEn && regAddr == fic_pkg::ADDR_CTRL1) begin
            wrCtrl1 = 1'b1;
        end
    end

    // Next control and flag state
    always_comb begin
        flags_nxt   = flags_r;
        enables_nxt = enables_r;
        master_nxt  = master_r;
        testBit_nxt = testBit_r;
        if (wrCtrl0) begin
            master_nxt       = regWrData[fic_pkg::C0_MASTER];
            enables_nxt.ext0 = regWrData[fic_pkg::C0_EN_EXT0];
            enables_nxt.ext1 = regWrData[fic_pkg::C0_EN_EXT1];
            enables_nxt.tmr  = regWrData[fic_pkg::C0_EN_TMR];
            flags_nxt.ext0   = regWrData[fic_pkg::C0_FL_EXT0];
            flags_nxt.ext1   = regWrData[fic_pkg::C0_FL_EXT1];
            flags_nxt.tmr    = regWrData[fic_pkg::C0_FL_TMR];
            // Test bit is only stored; it steers nothing here
            testBit_nxt      = regWrData[fic_pkg::C0_TEST];
        end
        if (wrCtrl1) begin
            enables_nxt.tb   = regWrData[fic_pkg::C1_EN_TB];
            enables_nxt.rtc  = regWrData[fic_pkg::C1_EN_RTC];
            flags_nxt.tb     = regWrData[fic_pkg::C1_FL_TB];
            flags_nxt.rtc    = regWrData[fic_pkg::C1_FL_RTC];
        end
        // Return from interrupt re-arms; plain return does nothing here
        if (returnFromIrq) begin
            master_nxt = 1'b1;
        end
        // Acknowledge clears the served flag and the master enable
        if (ackGo) begin
            flags_nxt  = flags_nxt & ~grant;
            master_nxt = 1'b0;
        end
        // New events last so a set beats any clear in the same cycle
        flags_nxt = flags_nxt | events;
    end

    // Call request: vector registered, one cycle wide
    always_comb begin
        call_nxt.valid  = ackGo;
        call_nxt.vector = ackGo ? grantVec : call_r.vector;
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdData_nxt = 8'h00;
        if (regRdEn && regAddr == fic_pkg::ADDR_CTRL0) begin
            rdData_nxt[fic_pkg::C0_MASTER]  = master_r;
            rdData_nxt[fic_pkg::C0_EN_EXT0] = enables_r.ext0;
            rdData_nxt[fic_pkg::C0_EN_EXT1] = enables_r.ext1;
            rdData_nxt[fic_pkg::C0_EN_TMR]  = enables_r.tmr;
            rdData_nxt[fic_pkg::C0_FL_EXT0] = flags_r.ext0;
            rdData_nxt[fic_pkg::C0_FL_EXT1] = flags_r.ext1;
            rdData_nxt[fic_pkg::C0_FL_TMR]  = flags_r.tmr;
            rdData_nxt[fic_pkg::C0_TEST]    = testBit_r;
        end else if (regRdEn && regAddr == fic_pkg::ADDR_CTRL1) begin
            rdData_nxt[fic_pkg::C1_EN_TB]   = enables_r.tb;
            rdData_nxt[fic_pkg::C1_EN_RTC]  = enables_r.rtc;
            rdData_nxt[fic_pkg::C1_FL_TB]   = flags_r.tb;
            rdData_nxt[fic_pkg::C1_FL_RTC]  = flags_r.rtc;
        end
    end

    // All state, frozen while the clock enable is low
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r   <= '0;
            enables_r <= '0;
            master_r  <= fic_pkg::CTRL0_RST[fic_pkg::C0_MASTER];
            testBit_r <= fic_pkg::CTRL0_RST[fic_pkg::C0_TEST];
            rdData_r  <= 8'h00;
            call_r    <= '0;
        end else if (clkEn) begin
            flags_r   <= flags_nxt;
            enables_r <= enables_nxt;
            master_r  <= master_nxt;
            testBit_r <= testBit_nxt;
            rdData_r  <= rdData_nxt;
            call_r    <= call_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign irqCall   = call_r;
    // Only the program counter is pushed, status stays untouched
    assign pushPc    = call_r.valid;
    // Wake ignores the master enable so a halted core always resumes
    assign wakeReq   = |pending;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_ack_ext0;
        ackGo && grant.ext0;
    endsequence

    sequence s_call_ext0;
        irqCall.valid && pushPc && irqCall.vector == fic_pkg::VEC_EXT0;
    endsequence

    property p_master_clr;
        ackGo |=> !master_r;
    endproperty
    a_master_clr: assert property (p_master_clr)
        else $error("master enable not cleared by acknowledge");

    property p_no_ack_masked;
        clkEn && !master_r |=> !irqCall.valid;
    endproperty
    a_no_ack_masked: assert property (p_no_ack_masked)
        else $error("acknowledge while master enable clear");

    property p_stack_full;
        clkEn && stackFull |=> !pushPc;
    endproperty
    a_stack_full: assert property (p_stack_full)
        else $error("acknowledge with full stack");

    property p_call_ext0;
        s_ack_ext0 |=> s_call_ext0;
    endproperty
    a_call_ext0: assert property (p_call_ext0)
        else $error("pin 0 call vector wrong");

    property p_call_tb;
        ackGo && grant.tb |=> irqCall.vector == fic_pkg::VEC_TB
            && !flags_r.tb | $past(timeBaseTick);
    endproperty
    a_call_tb: assert property (p_call_tb)
        else $error("time base service wrong");

    property p_prio;
        ackGo && pending.ext0 |-> grant.ext0 && grant == 5'h01;
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority order broken");

    property p_return_from_irq;
        clkEn && returnFromIrq && !ackGo |=> master_r;
    endproperty
    a_return_from_irq: assert property (p_return_from_irq)
        else $error("return from interrupt did not re-arm");

    property p_ret_plain;
        clkEn && returnSub && !returnFromIrq && !ackGo && !wrCtrl0
            |=> master_r == $past(master_r);
    endproperty
    a_ret_plain: assert property (p_ret_plain)
        else $error("plain return changed master enable");

    property p_tmr_set;
        clkEn && timerOvf |=> flags_r.tmr;
    endproperty
    a_tmr_set: assert property (p_tmr_set)
        else $error("timer overflow lost");

    property p_rtc_hold;
        clkEn && flags_r.rtc && !wrCtrl1 && !(ackGo && grant.rtc)
            |=> flags_r.rtc;
    endproperty
    a_rtc_hold: assert property (p_rtc_hold)
        else $error("clock tick flag dropped");

    property p_ctrl1_zero;
        clkEn && regRdEn && regAddr == fic_pkg::ADDR_CTRL1
            |=> regRdData[0] == 1'b0 && regRdData[4:3] == 2'h0
                && regRdData[7] == 1'b0;
    endproperty
    a_ctrl1_zero: assert property (p_ctrl1_zero)
        else $error("reserved control 1 bits not zero");

    property p_wake;
        clkEn && clockTick && enables_r.rtc && !wrCtrl1 |=> wakeReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("clock tick did not wake");

    sequence s_ack_tmr;
        ackGo && grant.tmr;
    endsequence

    property p_call_tmr;
        s_ack_tmr |=> irqCall.vector == fic_pkg::VEC_TMR && pushPc;
    endproperty
    a_call_tmr: assert property (p_call_tmr)
        else $error("timer call vector wrong");

    property p_call_ext1;
        ackGo && grant.ext1 |=> irqCall.vector == fic_pkg::VEC_EXT1;
    endproperty
    a_call_ext1: assert property (p_call_ext1)
        else $error("pin 1 call vector wrong");

    // Flag may only survive its service if a new tick lands at once
    property p_call_rtc;
        ackGo && grant.rtc && !wrCtrl1 |=> irqCall.vector == fic_pkg::VEC_RTC
            && (!flags_r.rtc || $past(clockTick));
    endproperty
    a_call_rtc: assert property (p_call_rtc)
        else $error("clock tick service wrong");

    // Master is already clear, so a call can never repeat next cycle
    property p_call_once;
        clkEn && irqCall.valid |=> !irqCall.valid;
    endproperty
    a_call_once: assert property (p_call_once)
        else $error("call pulse longer than one cycle");

    property p_flag_rd;
        clkEn && regRdEn && regAddr == fic_pkg::ADDR_CTRL0
            |=> regRdData[fic_pkg::C0_FL_TMR] == $past(flags_r.tmr);
    endproperty
    a_flag_rd: assert property (p_flag_rd)
        else $error("timer flag read back wrong");

endmodule

// file: rtl/fic_pkg.sv
// Package of constants and carriers for the five source interrupt controller
package fic_pkg;

    // Register addresses in the data space
    localparam logic [7:0] ADDR_CTRL0 = 8'h0B;
    localparam logic [7:0] ADDR_CTRL1 = 8'h1E;

    // Control 0 field positions
    localparam int C0_MASTER  = 0;
    localparam int C0_EN_EXT0 = 1;
    localparam int C0_EN_EXT1 = 2;
    localparam int C0_EN_TMR  = 3;
    localparam int C0_FL_EXT0 = 4;
    localparam int C0_FL_EXT1 = 5;
    localparam int C0_FL_TMR  = 6;
    localparam int C0_TEST    = 7;

    // Control 1 field positions
    localparam int C1_EN_TB   = 1;
    localparam int C1_EN_RTC  = 2;
    localparam int C1_FL_TB   = 5;
    localparam int C1_FL_RTC  = 6;

    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;

    // Call vectors
    localparam logic [7:0] VEC_EXT0 = 8'h04;
    localparam logic [7:0] VEC_EXT1 = 8'h08;
    localparam logic [7:0] VEC_TMR  = 8'h0C;
    localparam logic [7:0] VEC_TB   = 8'h14;
    localparam logic [7:0] VEC_RTC  = 8'h18;

    // Edge selection codes for the external pins
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    localparam int NUM_SRC = 5;

    // One bit per source, lowest bit is the highest priority
    typedef struct packed {
        logic rtc;
        logic tb;
        logic tmr;
        logic ext1;
        logic ext0;
    } fic_src_t;

    // Call request towards the core sequencer
    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } fic_call_t;

endpackage

// file: rtl/fic_pin_edge.sv
// Pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module fic_pin_edge #(
    parameter logic [1:0] EDGE_MODE = fic_pkg::EDGE_FALL
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // Pin and event
    input  wire logic pinRaw,
    output logic      edgePulse
);

    if (EDGE_MODE > fic_pkg::EDGE_BOTH) begin : g_chk
        $error("fic_pin_edge: unsupported edge mode");
    end

    logic syncA_r, syncB_r, prev_r;
    logic syncA_nxt, syncB_nxt, prev_nxt;

    // Next values; the first stage feeds only the second
    always_comb begin
        syncA_nxt = pinRaw;
        syncB_nxt = syncA_r;
        prev_nxt  = syncB_r;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_r <= 1'b1;
            syncB_r <= 1'b1;
            prev_r  <= 1'b1;
        end else if (clkEn) begin
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // Edge qualified by the build option, one pulse per edge
    always_comb begin
        case (EDGE_MODE)
            fic_pkg::EDGE_RISE: edgePulse = syncB_r & ~prev_r;
            fic_pkg::EDGE_BOTH: edgePulse = syncB_r ^ prev_r;
            default:            edgePulse = ~syncB_r & prev_r;
        endcase
    end

endmodule

// file: rtl/fic_prio.sv
// Fixed priority selector with vector lookup
`timescale 1ns/1ps
module fic_prio (
    // Requests, lowest bit first
    input  fic_pkg::fic_src_t req,
    // Selection
    output fic_pkg::fic_src_t grant,
    output logic [7:0]        vector,
    output logic              any
);

    localparam logic [7:0] VEC_TAB [fic_pkg::NUM_SRC] = '{
        fic_pkg::VEC_EXT0, fic_pkg::VEC_EXT1, fic_pkg::VEC_TMR,
        fic_pkg::VEC_TB,   fic_pkg::VEC_RTC};

    // First set bit wins, so pin 0 beats everything
    always_comb begin
        logic found;
        found  = 1'b0;
        grant  = '0;
        vector = 8'h00;
        for (int i = 0; i < fic_pkg::NUM_SRC; i++) begin
            if (req[i] && !found) begin
                found    = 1'b1;
                grant[i] = 1'b1;
                vector   = VEC_TAB[i];
            end
        end
        any = found;
    end

endmodule

// file: sim/fic_core_model.sv
// Core sequencer and return stack model facing the interrupt controller
`timescale 1ns/1ps
module fic_core_model #(
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Bench commands
    input  wire logic stall,
    input  wire logic doRetIrq,
    input  wire logic doRetSub,
    // Controller side
    input  wire logic pushPc,
    output logic      coreAccept,
    output logic      stackFull,
    output logic      returnFromIrq,
    output logic      returnSub
);
    int spDepth_r;

    // A stalled core is away from an instruction boundary
    assign coreAccept = ~stall;
    // Full stack must hold every call off, enabled or not
    assign stackFull  = (spDepth_r >= DEPTH);

    // Only the program counter is stacked; each return pops one entry unless the stack is empty
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            spDepth_r     <= 0;
            returnFromIrq <= 1'b0;
            returnSub     <= 1'b0;
        end else begin
            returnFromIrq <= doRetIrq;
            returnSub     <= doRetSub;
            spDepth_r     <= spDepth_r + int'(pushPc)
                - int'((doRetIrq | doRetSub) && spDepth_r > 0);
        end
    end
endmodule

// file: sim/tb_fic_irq_ctrl.sv
// Self-checking bench for the five source interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_fic_irq_ctrl;
    // Clock, reset and register port
    logic               clk_sys       = 1'b0;
    logic               sys_rst       = 1'b1;
    logic [7:0]         regAddr       = 8'h00;
    logic [7:0]         regWrData     = 8'h00;
    logic               regWrEn       = 1'b0;
    logic               regRdEn       = 1'b0;
    logic [7:0]         regRdData;
    // Sources, core and bench state
    logic               extIrqPinZero = 1'b1;
    logic               extIrqPinOne  = 1'b1;
    logic               timerOvf      = 1'b0;
    logic               timeBaseTick  = 1'b0;
    logic               clockTick     = 1'b0;
    logic               stall         = 1'b0;
    logic               clkEn         = 1'b1;
    logic               doRetIrq      = 1'b0;
    logic               doRetSub      = 1'b0;
    logic               coreAccept, stackFull, returnFromIrq, returnSub;
    logic               pushPc, wakeReq, rdSeen;
    fic_pkg::fic_call_t irqCall;
    int                 mismatches    = 0;
    int                 checked       = 0;
    logic [7:0]         callQ[$], rdQ[$];
    logic [7:0]         vecs[5];
    logic [7:0]         en, fl, a, c0, expV;
    integer             seed          = 32'h6AF792A2;

    always #4 clk_sys = ~clk_sys;

    // Pin 1 on rising edges so the falling and rising detector modes both get exercised
    fic_irq_ctrl #(.EDGE_PIN1(fic_pkg::EDGE_RISE)) uut (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData),
        .extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne),
        .timerOvf(timerOvf), .timeBaseTick(timeBaseTick),
        .clockTick(clockTick), .coreAccept(coreAccept),
        .stackFull(stackFull), .returnFromIrq(returnFromIrq),
        .returnSub(returnSub), .irqCall(irqCall), .pushPc(pushPc),
        .wakeReq(wakeReq));

    fic_core_model #(.DEPTH(4)) core (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .stall(stall), .doRetIrq(doRetIrq), .doRetSub(doRetSub),
        .pushPc(pushPc), .coreAccept(coreAccept), .stackFull(stackFull),
        .returnFromIrq(returnFromIrq), .returnSub(returnSub));

    // Pair each call or read with the oldest note; falling edge, as settled
    always @(negedge clk_sys) begin
        `CHK(pushPc, irqCall.valid)
        if (irqCall.valid === 1'b1) begin
            if (callQ.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                expV = callQ.pop_front();
                `CHK(irqCall.vector, expV)
            end
        end
        if (rdSeen === 1'b1) begin
            expV = rdQ.pop_front();
            `CHK(regRdData, expV)
        end
        rdSeen = regRdEn;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr   <= ad;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk_sys);
        regWrEn   <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        rdQ.push_back(e);
        @(posedge clk_sys);
        regAddr <= ad;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
    endtask

    task automatic ret(input logic irq);
        @(posedge clk_sys);
        doRetIrq <= irq;
        doRetSub <= ~irq;
        @(posedge clk_sys);
        doRetIrq <= 1'b0;
        doRetSub <= 1'b0;
    endtask

    // Bounded wait for all noted calls
    task automatic drain;
        int k;
        for (k = 0; k < 60 && callQ.size() != 0; k++) @(posedge clk_sys);
        if (callQ.size() != 0) `CHK(1'b0, 1'b1)
        idle(3);
    endtask

    // Pins go low for four cycles so fall and rise both reach the flag
    task automatic fire(input int i);
        @(posedge clk_sys);
        case (i)
            0: extIrqPinZero <= 1'b0;
            1: extIrqPinOne <= 1'b0;
            2: timerOvf <= 1'b1;
            3: timeBaseTick <= 1'b1;
            default: clockTick <= 1'b1;
        endcase
        @(posedge clk_sys);
        {timerOvf, timeBaseTick, clockTick} <= 3'b000;
        idle(3);
        extIrqPinZero <= 1'b1;
        extIrqPinOne  <= 1'b1;
        idle(6);
    endtask

    task automatic results;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the expected run
    initial begin
        #160000;
        mismatches++;
        results();
    end

    initial begin
        vecs = '{fic_pkg::VEC_EXT0, fic_pkg::VEC_EXT1, fic_pkg::VEC_TMR,
                 fic_pkg::VEC_TB, fic_pkg::VEC_RTC};
        rdSeen = 1'b0;
        idle(4);
        sys_rst <= 1'b0;
        rd(fic_pkg::ADDR_CTRL0, fic_pkg::CTRL0_RST);
        rd(fic_pkg::ADDR_CTRL1, fic_pkg::CTRL1_RST);
        // Random fills while stalled, so nothing may be taken
        stall <= 1'b1;
        repeat (4) begin
            c0 = 8'($random(seed));
            wr(fic_pkg::ADDR_CTRL0, c0 & 8'h7F);
            rd(fic_pkg::ADDR_CTRL0, c0 & 8'h7F);
            wr(fic_pkg::ADDR_CTRL1, c0);
            rd(fic_pkg::ADDR_CTRL1, c0 & 8'h66);
            wr(8'h0C, c0);
            rd(8'h0C, 8'h00);
        end
        wr(fic_pkg::ADDR_CTRL0, 8'h00);
        wr(fic_pkg::ADDR_CTRL1, 8'h00);
        stall <= 1'b0;
        // Each source alone: flag, wake, refused, then served
        for (int i = 0; i < 5; i++) begin
            en = (i < 3) ? 8'(2 << i) : 8'(2 << (i - 3));
            fl = (i < 3) ? 8'(16 << i) : 8'(32 << (i - 3));
            a  = (i < 3) ? fic_pkg::ADDR_CTRL0 : fic_pkg::ADDR_CTRL1;
            wr(a, en);
            fire(i);
            `CHK(wakeReq, 1'b1)
            rd(a, en | fl);
            stall <= 1'b1;
            callQ.push_back(vecs[i]);
            wr(fic_pkg::ADDR_CTRL0, (i < 3) ? (en | fl | 8'h01) : 8'h01);
            idle(4);
            `CHK(callQ.size() == 1, 1'b1)
            stall <= 1'b0;
            drain();
            rd(a, en);
            ret(1'b0);
            rd(fic_pkg::ADDR_CTRL0, (i < 3) ? en : 8'h00);
            `CHK(wakeReq, 1'b0)
        end
        // All five pending; master re-armed in each handler to nest
        wr(fic_pkg::ADDR_CTRL1, 8'h66);
        c0 = 8'h7E;
        wr(fic_pkg::ADDR_CTRL0, c0);
        for (int k = 0; k < 4; k++) begin
            callQ.push_back(vecs[k]);
            wr(fic_pkg::ADDR_CTRL0, c0 | 8'h01);
            drain();
            if (k < 3) c0 = c0 & ~(8'h10 << k);
            rd(fic_pkg::ADDR_CTRL0, c0);
        end
        // Stack now full: enabled clock tick must wait
        wr(fic_pkg::ADDR_CTRL0, 8'h0F);
        idle(10);
        rd(fic_pkg::ADDR_CTRL1, 8'h46);
        callQ.push_back(vecs[4]);
        // Stack frees up while frozen; the call must wait for the enable
        clkEn <= 1'b0;
        ret(1'b0);
        idle(4);
        `CHK(callQ.size() == 1, 1'b1)
        clkEn <= 1'b1;
        drain();
        rd(fic_pkg::ADDR_CTRL0, 8'h0E);
        rd(fic_pkg::ADDR_CTRL1, 8'h06);
        ret(1'b1);
        idle(2);
        rd(fic_pkg::ADDR_CTRL0, 8'h0F);
        idle(4);
        results();
    end
endmodule
